// ---- verilog/drt_pkg.sv ----
// package with offsets, field layouts, reset values and state types of the tuning register bank
`default_nettype none
package drt_pkg;
  // register file geometry: one byte per address, addresses 00h to 1Ah kept
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NUM_REGS = 27;
  localparam logic [4:0] LAST_ADDR = 5'h1A;
  // register offsets
  localparam logic [4:0] TX_CONFIG = 5'h01;
  localparam logic [4:0] OSC_FREQ_BYTE0 = 5'h04;
  localparam logic [4:0] OSC_FREQ_BYTE1 = 5'h05;
  localparam logic [4:0] OSC_FREQ_BYTE2 = 5'h06;
  localparam logic [4:0] OSC_FREQ_BYTE3 = 5'h07;
  localparam logic [4:0] OSC_FREQ_BYTE4 = 5'h08;
  localparam logic [4:0] IQ_PHASE_FIX_LOW = 5'h09;
  localparam logic [4:0] IQ_PHASE_FIX_HIGH = 5'h0A;
  localparam logic [4:0] CHAN_A_DIG_GAIN_LOW = 5'h0B;
  localparam logic [4:0] CHAN_A_DIG_GAIN_HIGH = 5'h0C;
  localparam logic [4:0] CHAN_B_DIG_GAIN_LOW = 5'h0D;
  localparam logic [4:0] CHAN_B_DIG_GAIN_HIGH = 5'h0E;
  localparam logic [4:0] OUTPUT_CONTROL = 5'h0F;
  localparam logic [4:0] CLIP_LEVEL = 5'h10;
  localparam logic [4:0] CHAN_A_OFFSET_LOW = 5'h11;
  localparam logic [4:0] CHAN_A_OFFSET_HIGH = 5'h12;
  localparam logic [4:0] CHAN_B_OFFSET_LOW = 5'h13;
  localparam logic [4:0] CHAN_B_OFFSET_HIGH = 5'h14;
  localparam logic [4:0] OSC_PHASE_LOW = 5'h15;
  localparam logic [4:0] OSC_PHASE_HIGH = 5'h16;
  localparam logic [4:0] CHAN_A_ANALOG_GAIN_LOW = 5'h17;
  localparam logic [4:0] CHAN_A_ANALOG_GAIN_HIGH = 5'h18;
  localparam logic [4:0] CHAN_B_ANALOG_GAIN_LOW = 5'h19;
  localparam logic [4:0] CHAN_B_ANALOG_GAIN_HIGH = 5'h1A;
  // writable bit masks: all bits, no bits, and those of the partly filled registers
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_TX_CONFIG = 8'hC0;
  localparam logic [7:0] MASK_IQ_HIGH = 8'h9F;
  localparam logic [7:0] MASK_DIG_GAIN_HIGH = 8'h0F;
  localparam logic [7:0] MASK_OUTPUT_CONTROL = 8'h0F;
  localparam logic [7:0] MASK_ANALOG_GAIN_HIGH = 8'hC0;
  // field positions
  localparam int unsigned OSC_RUN_BIT = 7;
  localparam int unsigned OSC_LOW_POWER_BIT = 6;
  localparam int unsigned IQ_FIX_ON_BIT = 7;
  localparam int unsigned IQ_HIGH_MSB = 4;
  localparam int unsigned DIG_GAIN_HIGH_MSB = 3;
  localparam int unsigned CHAN_A_GAIN_ON_BIT = 3;
  localparam int unsigned CHAN_B_GAIN_ON_BIT = 2;
  localparam int unsigned ATTENUATE_BIT = 1;
  localparam int unsigned CLIP_ON_BIT = 0;
  localparam int unsigned ANALOG_HIGH_MSB = 7;
  localparam int unsigned ANALOG_HIGH_LSB = 6;
  localparam int unsigned LOW_POWER_LSB = 3;
  // widths
  localparam int unsigned FREQ_W = 40;
  localparam int unsigned PHASE_W = 16;
  localparam int unsigned LP_W = 5;
  localparam int unsigned SAMPLE_W = 16;
  // value of every register after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  // state of the register bank
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [12:0] iq_applied;
    logic [SAMPLE_W-1:0] sample_a;
    logic [SAMPLE_W-1:0] sample_b;
  } drt_bank_type;
  localparam drt_bank_type BANK_RESET = '0;
  // state of the oscillator phase accumulator
  typedef struct packed {
    logic [FREQ_W-1:0] acc;
    logic [PHASE_W-1:0] phase;
  } drt_osc_type;
  localparam drt_osc_type OSC_RESET = '0;
endpackage : drt_pkg
`default_nettype wire

// ---- verilog/drt_osc_accum.sv ----
// oscillator phase accumulator with full and five-bit low-power modes
`default_nettype none
module drt_osc_accum
  import drt_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // settings from the register bank
  input wire logic osc_run_i,
  input wire logic osc_low_power_select_i,
  input wire logic [FREQ_W-1:0] osc_frequency_word_i,
  input wire logic [PHASE_W-1:0] osc_phase_offset_i,
  input wire logic [LP_W-1:0] lp_freq_i,
  input wire logic [LP_W-1:0] lp_phase_i,
  // instantaneous phase
  output logic [PHASE_W-1:0] osc_phase_o
);
  drt_osc_type st_q;
  drt_osc_type st_d;

  // next accumulator and phase; stopping forces the phase to zero
  always_comb begin
    st_d = st_q;
    if (!osc_run_i) begin
      st_d.acc = '0;
      st_d.phase = '0;
    end else if (osc_low_power_select_i) begin
      // low power: only the top five bits move, the rest stay at zero
      st_d.acc = {LP_W'(st_q.acc[FREQ_W-1 -: LP_W] + lp_freq_i), {(FREQ_W-LP_W){1'b0}}};
      st_d.phase = {LP_W'(st_q.acc[FREQ_W-1 -: LP_W] + lp_phase_i), {(PHASE_W-LP_W){1'b0}}};
    end else begin
      st_d.acc = FREQ_W'(st_q.acc + osc_frequency_word_i);
      st_d.phase = PHASE_W'(st_q.acc[FREQ_W-1 -: PHASE_W] + osc_phase_offset_i);
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_q <= OSC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign osc_phase_o = st_q.phase;
endmodule : drt_osc_accum
`default_nettype wire

// ---- verilog/drt_tuning_regs.sv ----
// digital tuning register bank of the dual-channel converter with clipping and oscillator
`default_nettype none
module drt_tuning_regs
  import drt_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // byte register port from the serial control front end
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // sample path through the clipper
  input wire logic [SAMPLE_W-1:0] sample_a_i,
  input wire logic [SAMPLE_W-1:0] sample_b_i,
  output logic [SAMPLE_W-1:0] sample_a_o,
  output logic [SAMPLE_W-1:0] sample_b_o,
  // oscillator settings and phase
  output logic osc_run_o,
  output logic osc_low_power_select_o,
  output logic [FREQ_W-1:0] osc_frequency_word_o,
  output logic [PHASE_W-1:0] osc_phase_offset_o,
  output logic [PHASE_W-1:0] osc_phase_o,
  // phase correction
  output logic iq_phase_fix_on_o,
  output logic [12:0] iq_phase_factor_o,
  // digital gain and attenuation
  output logic [11:0] chan_a_digital_gain_o,
  output logic [11:0] chan_b_digital_gain_o,
  output logic chan_a_gain_on_o,
  output logic chan_b_gain_on_o,
  output logic output_attenuate_o,
  // clipping
  output logic clip_on_o,
  output logic [7:0] clip_level_o,
  // digital offsets
  output logic [15:0] chan_a_offset_o,
  output logic [15:0] chan_b_offset_o,
  // analog gains
  output logic [9:0] chan_a_analog_gain_o,
  output logic [9:0] chan_b_analog_gain_o
);
  drt_bank_type st_q;
  drt_bank_type st_d;

  // writable bits of an address; zero for unmapped addresses, used by write and read
  function automatic logic [7:0] field_mask(input logic [ADDR_W-1:0] addr);
    logic [7:0] m;
    m = MASK_NONE;
    case (addr)
      TX_CONFIG: m = MASK_TX_CONFIG;
      OSC_FREQ_BYTE0, OSC_FREQ_BYTE1, OSC_FREQ_BYTE2, OSC_FREQ_BYTE3, OSC_FREQ_BYTE4: m = MASK_FULL;
      IQ_PHASE_FIX_LOW: m = MASK_FULL;
      IQ_PHASE_FIX_HIGH: m = MASK_IQ_HIGH;
      CHAN_A_DIG_GAIN_LOW, CHAN_B_DIG_GAIN_LOW: m = MASK_FULL;
      CHAN_A_DIG_GAIN_HIGH, CHAN_B_DIG_GAIN_HIGH: m = MASK_DIG_GAIN_HIGH;
      OUTPUT_CONTROL: m = MASK_OUTPUT_CONTROL;
      CLIP_LEVEL: m = MASK_FULL;
      CHAN_A_OFFSET_LOW, CHAN_A_OFFSET_HIGH, CHAN_B_OFFSET_LOW, CHAN_B_OFFSET_HIGH: m = MASK_FULL;
      OSC_PHASE_LOW, OSC_PHASE_HIGH: m = MASK_FULL;
      CHAN_A_ANALOG_GAIN_LOW, CHAN_B_ANALOG_GAIN_LOW: m = MASK_FULL;
      CHAN_A_ANALOG_GAIN_HIGH, CHAN_B_ANALOG_GAIN_HIGH: m = MASK_ANALOG_GAIN_HIGH;
      default: m = MASK_NONE;
    endcase
    return m;
  endfunction : field_mask

  // limit a signed sample to the level placed in bits 14 to 7, below the sign bit, and to the bitwise inverse of that bound
  function automatic logic [SAMPLE_W-1:0] clip_sample(input logic [SAMPLE_W-1:0] s, input logic [7:0] level,
                                                     input logic on);
    logic signed [SAMPLE_W-1:0] hi;
    logic signed [SAMPLE_W-1:0] lo;
    logic signed [SAMPLE_W-1:0] v;
    hi = {1'b0, level, 7'h7F};
    lo = ~hi;
    v = s;
    if (on && (v > hi)) begin
      v = hi;
    end else if (on && (v < lo)) begin
      v = lo;
    end
    return v;
  endfunction : clip_sample

  // register fields, decoded once for both the outputs and the datapath
  logic [7:0] tx_cfg;
  logic [7:0] out_ctl;
  logic [12:0] iq_factor;
  logic iq_on;
  logic clip_on;
  logic [7:0] clip_level;
  assign tx_cfg = st_q.regs[TX_CONFIG];
  assign out_ctl = st_q.regs[OUTPUT_CONTROL];
  // upper five bits come from the high register, the low eight from the low one
  assign iq_factor = {st_q.regs[IQ_PHASE_FIX_HIGH][IQ_HIGH_MSB:0], st_q.regs[IQ_PHASE_FIX_LOW]};
  assign iq_on = st_q.regs[IQ_PHASE_FIX_HIGH][IQ_FIX_ON_BIT];
  assign clip_on = out_ctl[CLIP_ON_BIT];
  assign clip_level = st_q.regs[CLIP_LEVEL];

  // next state: register writes, registered read data, correction gate and clipper
  always_comb begin
    st_d = st_q;
    st_d.rd_valid = 1'b0;
    // writes only touch assigned bits; out-of-range addresses are dropped
    if (wr_en_i && (addr_i <= LAST_ADDR)) begin
      st_d.regs[addr_i] = (st_q.regs[addr_i] & ~field_mask(addr_i)) | (wr_data_i & field_mask(addr_i));
    end
    // read returns stored bits, unassigned bits and unmapped addresses give zero
    if (rd_en_i) begin
      st_d.rd_valid = 1'b1;
      if (addr_i <= LAST_ADDR) begin
        st_d.rd_data = st_q.regs[addr_i] & field_mask(addr_i);
      end else begin
        st_d.rd_data = 8'h00;
      end
    end
    // correction factor reaches the outputs one cycle after each cycle in which it is enabled
    st_d.iq_applied = iq_on ? iq_factor : 13'h0000;
    // one clipper per channel, same level for both
    st_d.sample_a = clip_sample(sample_a_i, clip_level, clip_on);
    st_d.sample_b = clip_sample(sample_b_i, clip_level, clip_on);
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_q <= BANK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // oscillator; a write to the run bit takes effect one cycle later
  drt_osc_accum u_osc (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .osc_run_i(osc_run_o),
    .osc_low_power_select_i(osc_low_power_select_o),
    .osc_frequency_word_i(osc_frequency_word_o),
    .osc_phase_offset_i(osc_phase_offset_o),
    .lp_freq_i(st_q.regs[OSC_FREQ_BYTE2][7:LOW_POWER_LSB]),
    .lp_phase_i(st_q.regs[OSC_FREQ_BYTE4][7:LOW_POWER_LSB]),
    .osc_phase_o(osc_phase_o)
  );

  // read port
  assign rd_data_o = st_q.rd_data;
  assign rd_valid_o = st_q.rd_valid;
  // clipped samples, one cycle behind the inputs
  assign sample_a_o = st_q.sample_a;
  assign sample_b_o = st_q.sample_b;
  // oscillator control and settings
  assign osc_run_o = tx_cfg[OSC_RUN_BIT];
  assign osc_low_power_select_o = tx_cfg[OSC_LOW_POWER_BIT];
  // byte 0 is least significant, byte 4 most
  assign osc_frequency_word_o = {st_q.regs[OSC_FREQ_BYTE4], st_q.regs[OSC_FREQ_BYTE3], st_q.regs[OSC_FREQ_BYTE2],
                                 st_q.regs[OSC_FREQ_BYTE1], st_q.regs[OSC_FREQ_BYTE0]};
  assign osc_phase_offset_o = {st_q.regs[OSC_PHASE_HIGH], st_q.regs[OSC_PHASE_LOW]};
  // phase correction, gated copy
  assign iq_phase_fix_on_o = iq_on;
  assign iq_phase_factor_o = st_q.iq_applied;
  // digital gain
  assign chan_a_digital_gain_o = {st_q.regs[CHAN_A_DIG_GAIN_HIGH][DIG_GAIN_HIGH_MSB:0],
                                  st_q.regs[CHAN_A_DIG_GAIN_LOW]};
  assign chan_b_digital_gain_o = {st_q.regs[CHAN_B_DIG_GAIN_HIGH][DIG_GAIN_HIGH_MSB:0],
                                  st_q.regs[CHAN_B_DIG_GAIN_LOW]};
  assign chan_a_gain_on_o = out_ctl[CHAN_A_GAIN_ON_BIT];
  assign chan_b_gain_on_o = out_ctl[CHAN_B_GAIN_ON_BIT];
  assign output_attenuate_o = out_ctl[ATTENUATE_BIT];
  // clipping
  assign clip_on_o = clip_on;
  assign clip_level_o = clip_level;
  // offsets
  assign chan_a_offset_o = {st_q.regs[CHAN_A_OFFSET_HIGH], st_q.regs[CHAN_A_OFFSET_LOW]};
  assign chan_b_offset_o = {st_q.regs[CHAN_B_OFFSET_HIGH], st_q.regs[CHAN_B_OFFSET_LOW]};
  // analog gain: top two bits sit in bits seven and six
  assign chan_a_analog_gain_o = {st_q.regs[CHAN_A_ANALOG_GAIN_HIGH][ANALOG_HIGH_MSB:ANALOG_HIGH_LSB],
                                 st_q.regs[CHAN_A_ANALOG_GAIN_LOW]};
  assign chan_b_analog_gain_o = {st_q.regs[CHAN_B_ANALOG_GAIN_HIGH][ANALOG_HIGH_MSB:ANALOG_HIGH_LSB],
                                 st_q.regs[CHAN_B_ANALOG_GAIN_LOW]};
endmodule : drt_tuning_regs
`default_nettype wire

// ---- sim/drt_tuning_regs_assertions.sv ----
// checker of the tuning register bank port behaviour
`default_nettype none
module drt_tuning_regs_assertions
  import drt_pkg::*;
(
  // clock, reset and register port
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_valid_o,
  // watched fields and paths
  input wire logic [SAMPLE_W-1:0] sample_a_i,
  input wire logic [SAMPLE_W-1:0] sample_a_o,
  input wire logic osc_run_o,
  input wire logic [PHASE_W-1:0] osc_phase_o,
  input wire logic iq_phase_fix_on_o,
  input wire logic [12:0] iq_phase_factor_o,
  input wire logic [FREQ_W-1:0] osc_frequency_word_o,
  input wire logic [11:0] chan_a_digital_gain_o,
  input wire logic chan_a_gain_on_o,
  input wire logic chan_b_gain_on_o,
  input wire logic output_attenuate_o,
  input wire logic clip_on_o,
  input wire logic [9:0] chan_a_analog_gain_o
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  chk_read_answer: assert property (rd_en_i |=> rd_valid_o) else $error("read not answered");
  chk_no_spur_valid: assert property (!rd_en_i |=> !rd_valid_o) else $error("read valid without read");
  chk_freq_low: assert property (wr_en_i && addr_i == OSC_FREQ_BYTE0 |=>
    osc_frequency_word_o[7:0] == $past(wr_data_i)) else $error("frequency low byte wrong");
  chk_freq_top: assert property (wr_en_i && addr_i == OSC_FREQ_BYTE4 |=>
    osc_frequency_word_o[39:32] == $past(wr_data_i)) else $error("frequency top byte wrong");
  chk_gain_high: assert property (wr_en_i && addr_i == CHAN_A_DIG_GAIN_HIGH |=>
    chan_a_digital_gain_o[11:8] == $past(wr_data_i[3:0])) else $error("gain high bits wrong");
  chk_ctrl_bits: assert property (wr_en_i && addr_i == OUTPUT_CONTROL |=>
    {chan_a_gain_on_o, chan_b_gain_on_o, output_attenuate_o, clip_on_o} == $past(wr_data_i[3:0]))
    else $error("output control bits wrong");
  chk_analog_top: assert property (wr_en_i && addr_i == CHAN_A_ANALOG_GAIN_HIGH |=>
    chan_a_analog_gain_o[9:8] == $past(wr_data_i[7:6])) else $error("analog gain top bits wrong");
  chk_iq_gate: assert property (!iq_phase_fix_on_o |=> iq_phase_factor_o == 13'h0000)
    else $error("phase factor applied while off");
  chk_osc_stop: assert property (!osc_run_o |=> osc_phase_o == 16'h0000) else $error("stopped phase not zero");
  chk_clip_pass: assert property (!clip_on_o |=> sample_a_o == $past(sample_a_i))
    else $error("sample altered with clipping off");
endmodule : drt_tuning_regs_assertions
bind drt_tuning_regs drt_tuning_regs_assertions chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_valid_o(rd_valid_o), .sample_a_i(sample_a_i),
  .sample_a_o(sample_a_o), .osc_run_o(osc_run_o), .osc_phase_o(osc_phase_o), .iq_phase_fix_on_o(iq_phase_fix_on_o),
  .iq_phase_factor_o(iq_phase_factor_o), .osc_frequency_word_o(osc_frequency_word_o),
  .chan_a_digital_gain_o(chan_a_digital_gain_o), .chan_a_gain_on_o(chan_a_gain_on_o),
  .chan_b_gain_on_o(chan_b_gain_on_o), .output_attenuate_o(output_attenuate_o), .clip_on_o(clip_on_o),
  .chan_a_analog_gain_o(chan_a_analog_gain_o));
`default_nettype wire

// ---- sim/drt_host_model.sv ----
// host model driving the byte register port of the tuning bank
`default_nettype none
module drt_host_model (
  // clock
  input wire logic clock_i,
  // register port towards the bank
  output logic wr_en_o = 1'b0,
  output logic rd_en_o = 1'b0,
  output logic [4:0] addr_o = 5'h00,
  output logic [7:0] wr_data_o = 8'h00,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // one byte write; released lines are inverted so a stale value never looks held
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wr_data_o <= d;
    @(posedge clock_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask : wr
  // one byte read, answer awaited for a few cycles only
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(posedge clock_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clock_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      if (rd_valid_i === 1'b1) begin
        d = rd_data_i;
        break;
      end
    end
  endtask : rd
endmodule : drt_host_model
`default_nettype wire

// ---- sim/drt_tuning_regs_tb.sv ----
// self-checking bench of the tuning register bank
`default_nettype none
module drt_tuning_regs_tb
  import drt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr, rd, rdv, run, lp, iqon, gaon, gbon, att, clon;
  logic [4:0] ad;
  logic [7:0] wd, rdd, cl, d;
  logic [15:0] sa = 16'h0000, sao, sbo, ph, ph1, pof, ofa, ofb;
  logic [39:0] fw;
  logic [12:0] iqf;
  logic [11:0] dga, dgb;
  logic [9:0] aga, agb;
  // pattern bytes kept in an array so that fields can be sliced out of them
  logic [7:0] pv [32];
  int fails = 0;
  int n_checks = 0;
  drt_host_model host (.clock_i(clock_i), .wr_en_o(wr), .rd_en_o(rd), .addr_o(ad), .wr_data_o(wd),
    .rd_data_i(rdd), .rd_valid_i(rdv));
  drt_tuning_regs uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .wr_en_i(wr), .rd_en_i(rd), .addr_i(ad),
    .wr_data_i(wd), .rd_data_o(rdd), .rd_valid_o(rdv), .sample_a_i(sa), .sample_b_i(sa), .sample_a_o(sao),
    .sample_b_o(sbo), .osc_run_o(run), .osc_low_power_select_o(lp), .osc_frequency_word_o(fw),
    .osc_phase_offset_o(pof), .osc_phase_o(ph), .iq_phase_fix_on_o(iqon), .iq_phase_factor_o(iqf),
    .chan_a_digital_gain_o(dga), .chan_b_digital_gain_o(dgb), .chan_a_gain_on_o(gaon), .chan_b_gain_on_o(gbon),
    .output_attenuate_o(att), .clip_on_o(clon), .clip_level_o(cl), .chan_a_offset_o(ofa), .chan_b_offset_o(ofb),
    .chan_a_analog_gain_o(aga), .chan_b_analog_gain_o(agb));
  // 50 MHz clock
  always #10 clock_i = ~clock_i;
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // distinct byte per address, chosen so enable and top bits come out mixed
  function automatic logic [7:0] p(input int a);
    return 8'h85 + 8'h0B * a[7:0];
  endfunction : p
  // writable bits per address
  function automatic logic [7:0] mask(input int a);
    case (a)
      1, 8'h18, 8'h1A: return 8'hC0;
      8'h0A: return 8'h9F;
      8'h0C, 8'h0E, 8'h0F: return 8'h0F;
      default: return (a >= 4 && a <= 8'h19) ? 8'hFF : 8'h00;
    endcase
  endfunction : mask
  // drive both sample inputs and look at the registered result
  task automatic smp(input logic [15:0] s, input logic [15:0] e);
    @(posedge clock_i);
    sa <= s;
    repeat (2) @(posedge clock_i);
    chk("sample a", sao, e);
    chk("sample b", sbo, e);
  endtask : smp
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      host.rd(a[4:0], d);
      chk("reset value", d, 8'h00);
      host.wr(a[4:0], 8'hFF);
      host.rd(a[4:0], d);
      chk("readback mask", d, mask(a));
    end
    for (int a = 4; a < 27; a++) begin
      pv[a] = p(a);
      host.wr(a[4:0], pv[a]);
    end
    repeat (2) @(posedge clock_i);
    chk("freq word", fw, {pv[8], pv[7], pv[6], pv[5], pv[4]});
    chk("iq factor", {iqon, iqf}, {1'b1, pv[10][4:0], pv[9]});
    chk("gain a", dga, {pv[12][3:0], pv[11]});
    chk("gain b", dgb, {pv[14][3:0], pv[13]});
    chk("ctrl bits", {gaon, gbon, att, clon}, pv[15][3:0]);
    chk("clip level", cl, p(16));
    chk("offsets", {ofb, ofa}, {p(20), p(19), p(18), p(17)});
    chk("phase offset", pof, {p(22), p(21)});
    chk("analog gains", {agb, aga}, {pv[26][7:6], pv[25], pv[24][7:6], pv[23]});
    host.wr(5'h0A, 8'h13);
    repeat (2) @(posedge clock_i);
    chk("iq off", {iqon, iqf}, 14'h0000);
    host.wr(5'h0F, 8'h05);
    // the write lands in the update step of the edge the task returns on, so look one edge later
    @(posedge clock_i);
    chk("ctrl clip", {gaon, gbon, att, clon}, 4'h5);
    smp(16'h7000, {1'b0, p(16), 7'h7F});
    smp(16'h8000, ~{1'b0, p(16), 7'h7F});
    smp(16'h0100, 16'h0100);
    host.wr(5'h0F, 8'h00);
    smp(16'h7000, 16'h7000);
    host.wr(5'h01, 8'h00);
    repeat (3) @(posedge clock_i);
    chk("osc stopped", ph, 16'h0000);
    chk("osc modes off", {run, lp}, 2'b00);
    host.wr(5'h06, 8'h08);
    host.wr(5'h08, 8'h00);
    host.wr(5'h01, 8'hC0);
    repeat (4) @(posedge clock_i);
    chk("osc modes lp", {run, lp}, 2'b11);
    ph1 = ph;
    @(posedge clock_i);
    chk("low power step", 16'(ph - ph1), 16'h0800);
    chk("low power lsbs", ph1[10:0], 11'h000);
    // full mode with only byte 3 set: the phase climbs by one each cycle
    host.wr(5'h04, 8'h00);
    host.wr(5'h05, 8'h00);
    host.wr(5'h06, 8'h00);
    host.wr(5'h07, 8'h01);
    host.wr(5'h01, 8'h80);
    repeat (3) @(posedge clock_i);
    chk("freq word full", fw, 40'h0001000000);
    chk("osc modes full", {run, lp}, 2'b10);
    ph1 = ph;
    @(posedge clock_i);
    chk("full step", 16'(ph - ph1), 16'h0001);
    finish_test();
  end
endmodule : drt_tuning_regs_tb
`default_nettype wire
